// File: hdl/dlc_pkg.sv
// Contract
// RQ1 - primary lane always runs; secondary lane only while enabled
// RQ2 - with secondary lane on, both lanes run each instruction on own data
// RQ3 - dual-lane bus transfers move two values per access, one per lane
// RQ4 - alu, multiplier and shifter each finish any operation in one cycle
// RQ5 - units handle 32-bit float, 40-bit extended float and 32-bit fixed; alu add, sub, logic ops and shifts work as 32-bit fixed in every format
// RQ6 - one instruction drives alu and multiplier in parallel, in both lanes
// RQ7 - each lane owns 32 registers, sixteen primary and sixteen alternate
// RQ8 - data bus carries data only; program bus carries fetches and data
// RQ9 - per cycle: two operands per bus plus one instruction from cache
// RQ10 - cache fills only on fetches that collided with program-bus data
// RQ11 - disabled secondary lane keeps its registers and results unchanged
// RQ12 - conflicting fetch hit serves cache data, leaving program bus to data
package dlc_pkg;
  localparam int LANES = 2;
  localparam int DW = 40;
  localparam int IW = 48;
  localparam int ADDR_W = 24;
  localparam int NREG_BANK = 16;
  localparam int NREGS = 32;
  localparam int RIX_W = 5;
  localparam int FIX_W = 32;
  localparam int FIX_LSB = 8;
  localparam int SIGN = 39;
  localparam int EXP_MSB = 38;
  localparam int EXP_LSB = 31;
  localparam int MANT_W = 31;
  localparam int SHAMT_W = 6;
  localparam logic [9:0] EXP_BIAS = 10'h07F;
  localparam logic [9:0] EXP_ONE = 10'h001;
  localparam logic [8:0] EXP_LIM = 9'h0FF;
  localparam logic [7:0] EXP_INF = 8'hFF;

  typedef enum logic [3:0] {
    ALU_NOP = 4'h0,
    ALU_PASS = 4'h1,
    ALU_ADD = 4'h2,
    ALU_SUB = 4'h3,
    ALU_AND = 4'h4,
    ALU_OR = 4'h5,
    ALU_XOR = 4'h6,
    ALU_ABS = 4'h7,
    ALU_NEG = 4'h8,
    ALU_LSL = 4'h9,
    ALU_LSR = 4'hA,
    ALU_ASR = 4'hB
  } dlc_alu_op_t;

  typedef enum logic [1:0] {
    MUL_NONE = 2'h0,
    MUL_FIX = 2'h1,
    MUL_FLT = 2'h2
  } dlc_mul_op_t;

  typedef enum logic [1:0] {
    FMT_FIX = 2'h0,
    FMT_F32 = 2'h1,
    FMT_F40 = 2'h2
  } dlc_fmt_t;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_BUS = 2'h1,
    SRC_CACHE = 2'h2,
    SRC_FILL = 2'h3
  } dlc_src_t;

  typedef struct packed {
    dlc_alu_op_t alu_op;
    dlc_mul_op_t mul_op;
    dlc_fmt_t fmt;
    logic [3:0] alu_dst;
    logic [3:0] alu_x;
    logic [3:0] alu_y;
    logic [3:0] mul_dst;
    logic [3:0] mul_x;
    logic [3:0] mul_y;
    logic dm_en;
    logic dm_we;
    logic [3:0] dm_reg;
    logic pm_en;
    logic pm_we;
    logic [3:0] pm_reg;
    logic [3:0] spare;
  } dlc_instr_t;

  typedef logic [LANES-1:0][DW-1:0] dlc_pair_t;

  typedef struct packed {
    logic req;
    logic we;
    logic instr;
    logic [LANES-1:0] lanes;
    logic [ADDR_W-1:0] addr;
    dlc_pair_t wdata;
  } dlc_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [LANES-1:0] lanes;
    logic [RIX_W-1:0] idx;
  } dlc_ld_t;

  typedef struct packed {
    dlc_src_t src;
    logic [ADDR_W-1:0] miss_addr;
    dlc_ld_t ld_dm;
    dlc_ld_t ld_pm;
    logic [LANES-1:0][NREGS-1:0][DW-1:0] regs;
  } dlc_core_st_t;
endpackage

// File: hdl/dlc_icache.sv
`timescale 1ns/1ns
module dlc_icache #(
  parameter int DEPTH = 16,
  parameter int AW = dlc_pkg::ADDR_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // lookup
  input wire logic lookup_en,
  input wire logic [AW-1:0] lookup_addr,
  output logic hit,
  output logic [dlc_pkg::IW-1:0] rdata,
  // fill
  input wire logic fill_en,
  input wire logic [AW-1:0] fill_addr,
  input wire logic [dlc_pkg::IW-1:0] fill_data
);
  localparam int IXW = $clog2(DEPTH);
  localparam int TW = AW - IXW;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || IXW >= AW)
  begin : g_bad_depth
    $error("cache depth must be a power of two below the address space");
  end

  typedef struct packed {
    logic [DEPTH-1:0] valid;
    logic [DEPTH-1:0][TW-1:0] tag;
    logic [DEPTH-1:0][dlc_pkg::IW-1:0] data;
    logic hit;
    logic [dlc_pkg::IW-1:0] rdata;
  } dlc_ic_st_t;

  dlc_ic_st_t st;
  dlc_ic_st_t next_st;

  function automatic logic [IXW-1:0] ix(input logic [AW-1:0] a);
    return a[IXW-1:0];
  endfunction

  always_comb
  begin
    next_st = st;
    next_st.hit = 1'b0;
    if (lookup_en)
    begin
      next_st.hit = st.valid[ix(lookup_addr)] &&
        st.tag[ix(lookup_addr)] == lookup_addr[AW-1:IXW]; // RQ12
      next_st.rdata = st.data[ix(lookup_addr)];
    end
    if (fill_en)
    begin
      next_st.valid[ix(fill_addr)] = 1'b1; // RQ10
      next_st.tag[ix(fill_addr)] = fill_addr[AW-1:IXW];
      next_st.data[ix(fill_addr)] = fill_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign hit = st.hit;
  assign rdata = st.rdata;
endmodule // dlc_icache

// File: hdl/dlc_core.sv
`timescale 1ns/1ns
module dlc_core #(
  parameter int CACHE_DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // mode control
  input wire logic secondary_lane_enable_bit,
  input wire logic alt_bank_select,
  // instruction fetch
  input wire logic fetch_valid,
  input wire logic [dlc_pkg::ADDR_W-1:0] fetch_addr,
  output logic fetch_ready,
  // address generators
  input wire logic [dlc_pkg::ADDR_W-1:0] address_generator_one,
  input wire logic [dlc_pkg::ADDR_W-1:0] address_generator_two,
  // data memory bus
  output dlc_pkg::dlc_bus_req_t data_memory_bus_req,
  input wire dlc_pkg::dlc_pair_t data_memory_bus_rdata,
  // program memory bus
  output dlc_pkg::dlc_bus_req_t program_memory_bus_req,
  input wire dlc_pkg::dlc_pair_t program_memory_bus_rdata,
  // status
  output logic exec_valid,
  output logic [dlc_pkg::LANES-1:0] lane_active
);
  if (CACHE_DEPTH < 2)
  begin : g_bad_cache
    $error("cache depth too small");
  end

  dlc_pkg::dlc_core_st_t st;
  dlc_pkg::dlc_core_st_t next_st;
  dlc_pkg::dlc_instr_t instr;
  logic [2*dlc_pkg::DW-1:0] pm_flat;
  logic [dlc_pkg::LANES-1:0] lane_on;
  logic ic_lookup;
  logic ic_fill;
  logic ic_hit;
  logic [dlc_pkg::IW-1:0] ic_rdata;
  logic miss;
  logic pm_data;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [dlc_pkg::RIX_W-1:0] reg_ix(
    input logic bank,
    input logic [3:0] r
  );
    return {bank, r}; // RQ7
  endfunction

  function automatic logic [dlc_pkg::DW-1:0] fix_pack(
    input logic [dlc_pkg::FIX_W-1:0] v
  );
    return {v, {dlc_pkg::FIX_LSB{1'b0}}};
  endfunction

  function automatic logic [dlc_pkg::DW-1:0] alu_fn(
    input dlc_pkg::dlc_alu_op_t op,
    input dlc_pkg::dlc_fmt_t fmt,
    input logic [dlc_pkg::DW-1:0] x,
    input logic [dlc_pkg::DW-1:0] y
  );
    logic [dlc_pkg::FIX_W-1:0] a;
    logic [dlc_pkg::FIX_W-1:0] b;
    logic [dlc_pkg::SHAMT_W-1:0] sh;
    logic flt;
    logic [dlc_pkg::DW-1:0] r;
    a = x[dlc_pkg::DW-1:dlc_pkg::FIX_LSB];
    b = y[dlc_pkg::DW-1:dlc_pkg::FIX_LSB];
    sh = b[dlc_pkg::SHAMT_W-1:0];
    flt = fmt != dlc_pkg::FMT_FIX; // RQ5
    case (op)
      dlc_pkg::ALU_PASS: r = x;
      dlc_pkg::ALU_ADD: r = fix_pack(a + b);
      dlc_pkg::ALU_SUB: r = fix_pack(a - b);
      dlc_pkg::ALU_AND: r = fix_pack(a & b);
      dlc_pkg::ALU_OR: r = fix_pack(a | b);
      dlc_pkg::ALU_XOR: r = fix_pack(a ^ b);
      dlc_pkg::ALU_ABS:
        r = flt ? {1'b0, x[dlc_pkg::SIGN-1:0]}
                : fix_pack(a[dlc_pkg::FIX_W-1] ? (~a + 32'h1) : a);
      dlc_pkg::ALU_NEG:
        r = flt ? {~x[dlc_pkg::SIGN], x[dlc_pkg::SIGN-1:0]}
                : fix_pack(~a + 32'h1);
      dlc_pkg::ALU_LSL: r = fix_pack(a << sh);
      dlc_pkg::ALU_LSR: r = fix_pack(a >> sh);
      dlc_pkg::ALU_ASR: r = fix_pack($unsigned($signed(a) >>> sh));
      default: r = x;
    endcase
    if (flt && fmt == dlc_pkg::FMT_F32)
      r[dlc_pkg::FIX_LSB-1:0] = '0;
    return r; // RQ4
  endfunction

  function automatic logic [dlc_pkg::DW-1:0] mul_fn(
    input dlc_pkg::dlc_mul_op_t op,
    input dlc_pkg::dlc_fmt_t fmt,
    input logic [dlc_pkg::DW-1:0] x,
    input logic [dlc_pkg::DW-1:0] y
  );
    logic s;
    logic [9:0] e;
    logic [63:0] p;
    logic [dlc_pkg::MANT_W-1:0] m;
    logic [dlc_pkg::DW-1:0] r;
    logic zx;
    logic zy;
    if (op == dlc_pkg::MUL_FIX)
    begin
      p = $unsigned($signed(x[dlc_pkg::DW-1:dlc_pkg::FIX_LSB]) *
                    $signed(y[dlc_pkg::DW-1:dlc_pkg::FIX_LSB]));
      return fix_pack(p[dlc_pkg::FIX_W-1:0]);
    end
    s = x[dlc_pkg::SIGN] ^ y[dlc_pkg::SIGN];
    zx = x[dlc_pkg::EXP_MSB:dlc_pkg::EXP_LSB] == '0;
    zy = y[dlc_pkg::EXP_MSB:dlc_pkg::EXP_LSB] == '0;
    p = {1'b1, x[dlc_pkg::MANT_W-1:0]} * {1'b1, y[dlc_pkg::MANT_W-1:0]};
    e = {2'b00, x[dlc_pkg::EXP_MSB:dlc_pkg::EXP_LSB]} +
        {2'b00, y[dlc_pkg::EXP_MSB:dlc_pkg::EXP_LSB]} - dlc_pkg::EXP_BIAS;
    if (p[63])
    begin
      m = p[62:32];
      e = e + dlc_pkg::EXP_ONE;
    end
    else
      m = p[61:31];
    if (zx || zy || e[9] || e == '0)
      r = {s, {(dlc_pkg::DW-1){1'b0}}};
    else if (e[8:0] >= dlc_pkg::EXP_LIM)
      r = {s, dlc_pkg::EXP_INF, {dlc_pkg::MANT_W{1'b0}}};
    else
      r = {s, e[7:0], m};
    if (fmt != dlc_pkg::FMT_F40)
      r[dlc_pkg::FIX_LSB-1:0] = '0; // RQ5
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // selective instruction cache

  dlc_icache #(
    .DEPTH(CACHE_DEPTH),
    .AW(dlc_pkg::ADDR_W)
  ) u_icache (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .lookup_en(ic_lookup),
    .lookup_addr(fetch_addr),
    .hit(ic_hit),
    .rdata(ic_rdata),
    .fill_en(ic_fill),
    .fill_addr(st.miss_addr),
    .fill_data(pm_flat[dlc_pkg::IW-1:0])
  );

  ////////////////////////////////////////////////////////////////////////////
  // execute, transfer and fetch

  always_comb
  begin
    next_st = st;
    next_st.ld_dm = '0;
    next_st.ld_pm = '0;
    next_st.src = dlc_pkg::SRC_NONE;
    pm_flat = program_memory_bus_rdata;
    instr = '0;
    exec_valid = 1'b0;
    case (st.src)
      dlc_pkg::SRC_BUS, dlc_pkg::SRC_FILL:
      begin
        instr = dlc_pkg::dlc_instr_t'(pm_flat[dlc_pkg::IW-1:0]);
        exec_valid = 1'b1;
      end
      dlc_pkg::SRC_CACHE:
      begin
        instr = dlc_pkg::dlc_instr_t'(ic_rdata); // RQ12
        exec_valid = ic_hit;
      end
      default: exec_valid = 1'b0;
    endcase
    miss = st.src == dlc_pkg::SRC_CACHE && !ic_hit;
    lane_on = {secondary_lane_enable_bit, 1'b1}; // RQ1
    lane_active = lane_on;

    for (int l = 0; l < dlc_pkg::LANES; l++)
    begin
      if (st.ld_dm.valid && st.ld_dm.lanes[l])
        next_st.regs[l][st.ld_dm.idx] = data_memory_bus_rdata[l]; // RQ3
      if (st.ld_pm.valid && st.ld_pm.lanes[l])
        next_st.regs[l][st.ld_pm.idx] = program_memory_bus_rdata[l]; // RQ3
      if (exec_valid && lane_on[l]) // RQ11
      begin
        if (instr.alu_op != dlc_pkg::ALU_NOP) // RQ2
          next_st.regs[l][reg_ix(alt_bank_select, instr.alu_dst)] =
            alu_fn(instr.alu_op, instr.fmt,
              st.regs[l][reg_ix(alt_bank_select, instr.alu_x)],
              st.regs[l][reg_ix(alt_bank_select, instr.alu_y)]);
        if (instr.mul_op != dlc_pkg::MUL_NONE) // RQ6
          next_st.regs[l][reg_ix(alt_bank_select, instr.mul_dst)] =
            mul_fn(instr.mul_op, instr.fmt,
              st.regs[l][reg_ix(alt_bank_select, instr.mul_x)],
              st.regs[l][reg_ix(alt_bank_select, instr.mul_y)]);
      end
    end

    data_memory_bus_req = '0;
    if (exec_valid && instr.dm_en) // RQ8
    begin
      data_memory_bus_req.req = 1'b1;
      data_memory_bus_req.we = instr.dm_we;
      data_memory_bus_req.lanes = lane_on; // RQ3
      data_memory_bus_req.addr = address_generator_one;
      for (int l = 0; l < dlc_pkg::LANES; l++)
        if (lane_on[l] && instr.dm_we)
          data_memory_bus_req.wdata[l] =
            st.regs[l][reg_ix(alt_bank_select, instr.dm_reg)];
      if (!instr.dm_we)
        next_st.ld_dm = {1'b1, lane_on,
          reg_ix(alt_bank_select, instr.dm_reg)}; // RQ9
    end

    pm_data = exec_valid && instr.pm_en;
    program_memory_bus_req = '0;
    if (pm_data) // RQ8
    begin
      program_memory_bus_req.req = 1'b1;
      program_memory_bus_req.we = instr.pm_we;
      program_memory_bus_req.lanes = lane_on; // RQ3
      program_memory_bus_req.addr = address_generator_two;
      for (int l = 0; l < dlc_pkg::LANES; l++)
        if (lane_on[l] && instr.pm_we)
          program_memory_bus_req.wdata[l] =
            st.regs[l][reg_ix(alt_bank_select, instr.pm_reg)];
      if (!instr.pm_we)
        next_st.ld_pm = {1'b1, lane_on,
          reg_ix(alt_bank_select, instr.pm_reg)}; // RQ9
    end

    ic_lookup = 1'b0;
    ic_fill = st.src == dlc_pkg::SRC_FILL; // RQ10
    fetch_ready = !miss;
    if (miss)
    begin
      program_memory_bus_req.req = 1'b1;
      program_memory_bus_req.instr = 1'b1;
      program_memory_bus_req.addr = st.miss_addr;
      next_st.src = dlc_pkg::SRC_FILL;
    end
    else if (fetch_valid)
    begin
      if (pm_data) // RQ9
      begin
        ic_lookup = 1'b1; // RQ12
        next_st.miss_addr = fetch_addr;
        next_st.src = dlc_pkg::SRC_CACHE;
      end
      else
      begin
        program_memory_bus_req.req = 1'b1; // RQ10
        program_memory_bus_req.instr = 1'b1;
        program_memory_bus_req.addr = fetch_addr;
        next_st.src = dlc_pkg::SRC_BUS;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end
endmodule // dlc_core

// File: verif/dlc_core_asserts.sv
`timescale 1ns/1ns
module dlc_core_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // mode and fetch
  input wire logic secondary_lane_enable_bit,
  input wire logic fetch_valid,
  input wire logic fetch_ready,
  // buses
  input wire dlc_pkg::dlc_bus_req_t data_memory_bus_req,
  input wire dlc_pkg::dlc_bus_req_t program_memory_bus_req,
  // status
  input wire logic exec_valid,
  input wire logic [dlc_pkg::LANES-1:0] lane_active
);
  dlc_pkg::dlc_bus_req_t dm;
  dlc_pkg::dlc_bus_req_t pm;
  assign dm = data_memory_bus_req;
  assign pm = program_memory_bus_req;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////
  lane_set_a: assert property (
    lane_active == {secondary_lane_enable_bit, 1'b1})
    else $error("lane activity wrong");
  dm_lanes_a: assert property (
    dm.req |-> dm.lanes == lane_active)
    else $error("data bus lanes wrong");
  pm_lanes_a: assert property (
    pm.req && !pm.instr |-> pm.lanes == lane_active)
    else $error("program bus lanes wrong");
  dm_data_a: assert property (
    dm.req |-> !dm.instr)
    else $error("fetch on data bus");
  off_wdata_a: assert property (
    dm.req && dm.we && !secondary_lane_enable_bit |-> dm.wdata[1] == '0)
    else $error("idle lane drives write data");
  miss_stall_a: assert property (
    !fetch_ready |-> !exec_valid && pm.req && pm.instr
      ##1 exec_valid && fetch_ready)
    else $error("miss handling wrong");
  fetch_exec_a: assert property (
    fetch_valid && fetch_ready && pm.req && pm.instr |=> exec_valid)
    else $error("fetched instruction not executed");
  hit_one_a: assert property (
    fetch_valid && fetch_ready && pm.req && !pm.instr
      |=> exec_valid == fetch_ready)
    else $error("conflict fetch outcome wrong");
  bus_exec_a: assert property (
    dm.req |-> exec_valid)
    else $error("data access without instruction");
  //////////////////////////////////////////////////////////////////////////
  miss_c: cover property (!fetch_ready);
  hit_c: cover property (pm.req && !pm.instr && fetch_valid ##1 exec_valid);
  dual_c: cover property (dm.req && dm.we && dm.lanes == 2'h3);
  single_c: cover property (dm.req && dm.we && dm.lanes == 2'h1);
endmodule // dlc_core_asserts

bind dlc_core dlc_core_asserts u_chk (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .secondary_lane_enable_bit(secondary_lane_enable_bit),
  .fetch_valid(fetch_valid),
  .fetch_ready(fetch_ready),
  .data_memory_bus_req(data_memory_bus_req),
  .program_memory_bus_req(program_memory_bus_req),
  .exec_valid(exec_valid),
  .lane_active(lane_active)
);

// File: verif/dlc_mem_model.sv
`timescale 1ns/1ns
module dlc_mem_model (
  // clock
  input wire logic clk_sys,
  // requests
  input wire dlc_pkg::dlc_bus_req_t dm_req,
  input wire dlc_pkg::dlc_bus_req_t pm_req,
  // read data
  output dlc_pkg::dlc_pair_t dm_rdata,
  output dlc_pkg::dlc_pair_t pm_rdata
);
  logic [47:0] imem [0:15];
  dlc_pkg::dlc_pair_t dmem [0:15];
  dlc_pkg::dlc_pair_t pmem [0:15];
  initial
  begin
    dm_rdata = '0;
    pm_rdata = '0;
  end
  // one-cycle answers; idle lines wander
  always @(posedge clk_sys)
  begin
    if (dm_req.req && !dm_req.we)
      dm_rdata <= dmem[dm_req.addr[3:0]];
    else
      dm_rdata <= ~dm_rdata;
    if (pm_req.req && pm_req.instr)
      pm_rdata <= dlc_pkg::dlc_pair_t'({32'h0, imem[pm_req.addr[3:0]]});
    else if (pm_req.req && !pm_req.we)
      pm_rdata <= pmem[pm_req.addr[3:0]];
    else
      pm_rdata <= ~pm_rdata;
    for (int l = 0; l < 2; l++)
    begin
      if (dm_req.req && dm_req.we && dm_req.lanes[l])
        dmem[dm_req.addr[3:0]][l] <= dm_req.wdata[l];
      if (pm_req.req && pm_req.we && !pm_req.instr && pm_req.lanes[l])
        pmem[pm_req.addr[3:0]][l] <= pm_req.wdata[l];
    end
  end
endmodule // dlc_mem_model

// File: verif/dlc_core_tb.sv
`timescale 1ns/1ns
module dlc_core_tb;
  logic clk_sys;
  logic rst_b;
  logic secondary_lane_enable_bit;
  logic alt_bank_select;
  logic fetch_valid;
  logic [dlc_pkg::ADDR_W-1:0] fetch_addr;
  logic fetch_ready;
  logic exec_valid;
  logic [dlc_pkg::LANES-1:0] lane_active;
  dlc_pkg::dlc_bus_req_t dm_req;
  dlc_pkg::dlc_bus_req_t pm_req;
  dlc_pkg::dlc_pair_t dm_rdata;
  dlc_pkg::dlc_pair_t pm_rdata;
  int n_mismatch;
  int checked;
  int cycles;
  localparam logic [79:0] OP_A = 80'h4040000000_3F80000000;
  localparam logic [79:0] OP_B = 80'h3F00000000_4000000000;
  localparam logic [79:0] SUM = 80'h7F40000000_7F80000000;
  localparam logic [79:0] PROD = 80'h3FC0000000_4000000000;
  dlc_core dut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .secondary_lane_enable_bit(secondary_lane_enable_bit),
    .alt_bank_select(alt_bank_select),
    .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr),
    .fetch_ready(fetch_ready),
    .address_generator_one(24'h000000),
    .address_generator_two(24'h000008),
    .data_memory_bus_req(dm_req),
    .data_memory_bus_rdata(dm_rdata),
    .program_memory_bus_req(pm_req),
    .program_memory_bus_rdata(pm_rdata),
    .exec_valid(exec_valid),
    .lane_active(lane_active)
  );
  dlc_mem_model mem (
    .clk_sys(clk_sys),
    .dm_req(dm_req),
    .pm_req(pm_req),
    .dm_rdata(dm_rdata),
    .pm_rdata(pm_rdata)
  );
  always #25 clk_sys = ~clk_sys;
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      n_mismatch++;
    end
  endtask
  function automatic logic [47:0] xfer(input logic pm, input logic we,
    input logic [3:0] r);
    dlc_pkg::dlc_instr_t i;
    i = '0;
    i.dm_en = !pm;
    i.dm_we = we;
    i.dm_reg = r;
    i.pm_en = pm;
    i.pm_we = we;
    i.pm_reg = r;
    return i;
  endfunction
  // loads, add and float multiply, stores
  task automatic init_mem();
    dlc_pkg::dlc_instr_t i;
    i = '0;
    i.alu_op = dlc_pkg::ALU_ADD;
    i.mul_op = dlc_pkg::MUL_FLT;
    i.fmt = dlc_pkg::FMT_F32;
    {i.alu_dst, i.alu_x, i.alu_y} = 12'h312;
    {i.mul_dst, i.mul_x, i.mul_y} = 12'h412;
    mem.imem = '{0: xfer(1'b0, 1'b0, 4'h1), 1: xfer(1'b1, 1'b0, 4'h2),
      3: i, 4: xfer(1'b0, 1'b1, 4'h3), 5: xfer(1'b1, 1'b1, 4'h4),
      default: 48'h0};
    mem.dmem[0] = OP_A;
    mem.pmem[8] = OP_B;
  endtask
  // sequencer: seven fetches, held while refused
  task automatic run_prog(output int stalls, output int execs);
    int pc;
    pc = 0;
    stalls = 0;
    execs = 0;
    for (int k = 0; k < 12; k++)
    begin
      fetch_valid = (pc < 7);
      fetch_addr = 24'(pc);
      @(negedge clk_sys);
      stalls += (fetch_ready === 1'b0);
      execs += (exec_valid === 1'b1);
      if (fetch_valid && fetch_ready === 1'b1)
        pc++;
      @(posedge clk_sys);
      #5;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic dual_lane_cold();
    int st;
    int ex;
    secondary_lane_enable_bit = 1'b1;
    init_mem();
    run_prog(st, ex);
    check(80'(ex), 80'h7);
    check(80'(st), 80'h2);
    check(mem.dmem[0], SUM);
    check(mem.pmem[8], PROD);
  endtask
  task automatic dual_lane_cached();
    int st;
    int ex;
    init_mem();
    run_prog(st, ex);
    check(80'(st), 80'h0);
    check(80'(ex), 80'h7);
    check(mem.dmem[0], SUM);
    check(mem.pmem[8], PROD);
  endtask
  task automatic single_lane_alt();
    int st;
    int ex;
    secondary_lane_enable_bit = 1'b0;
    alt_bank_select = 1'b1;
    init_mem();
    // no load of first operand: alternate one keeps its reset zero
    mem.imem[0] = 48'h000000000000;
    run_prog(st, ex);
    check(80'(ex), 80'h7);
    check(mem.dmem[0], {OP_A[79:40], OP_B[39:0]});
    check(mem.pmem[8], {OP_B[79:40], 40'h0000000000});
  endtask
  task automatic dual_lane_fixed();
    int st;
    int ex;
    dlc_pkg::dlc_instr_t i;
    secondary_lane_enable_bit = 1'b1;
    alt_bank_select = 1'b0;
    init_mem();
    i = dlc_pkg::dlc_instr_t'(mem.imem[3]);
    i.alu_op = dlc_pkg::ALU_SUB;
    i.mul_op = dlc_pkg::MUL_FIX;
    i.fmt = dlc_pkg::FMT_FIX;
    mem.imem[3] = i;
    run_prog(st, ex);
    check(80'(st), 80'h0);
    check(mem.dmem[0], 80'h0140000000_FF80000000);
    check(mem.pmem[8], 80'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 500)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    secondary_lane_enable_bit = 1'b0;
    alt_bank_select = 1'b0;
    fetch_valid = 1'b0;
    fetch_addr = 24'h000000;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    repeat (6) @(posedge clk_sys);
    #5;
    rst_b = 1'b1;
    dual_lane_cold();
    dual_lane_cached();
    single_lane_alt();
    dual_lane_fixed();
    end_sim();
  end
endmodule // dlc_core_tb
